// >>> rtl/gps_top.sv
// pin source-select register and the seven pin cells it steers
// assumes a register port already decoded to the general-purpose page
`timescale 1ns/1ps
`default_nettype none
`include "gps_map.svh"
module gps_top
  import gps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gps_reg_req_t req_i,
  output logic [15:0] rdata_o,
  input wire logic [7:1] out_val_i,
  input wire logic [7:1] oe_val_i,
  output logic [7:1] in_val_o,
  input wire logic [7:1] pin_i,
  output logic [7:1] pin_o,
  output logic [7:1] pin_oe_n_o
);
  logic [15:0] pin_sel_r;
  logic [15:0] pin_sel_nxt;
  wire logic hit;
  wire logic wr_hit;
  wire logic [15:0] rd_data;
  wire logic [15:0] rd_mux;

  // current code of each pin field
  wire gps_sel_t pin7_source_select;
  wire gps_sel_t pin6_source_select;
  wire gps_sel_t pin5_source_select;
  wire gps_sel_t pin4_source_select;
  wire gps_sel_t pin3_source_select;
  wire gps_sel_t pin2_source_select;
  wire gps_sel_t pin1_source_select;

  // next code of each pin field
  wire gps_sel_t pin7_sel_nxt;
  wire gps_sel_t pin6_sel_nxt;
  wire gps_sel_t pin5_sel_nxt;
  wire gps_sel_t pin4_sel_nxt;
  wire gps_sel_t pin3_sel_nxt;
  wire gps_sel_t pin2_sel_nxt;
  wire gps_sel_t pin1_sel_nxt;

  // select code handed to each pin cell
  wire gps_sel_t sel_of_pin [7:1];

  function automatic gps_sel_t field_of(input logic [15:0] r, input int k);
    field_of = r[k*`GPS_FIELD_W +: `GPS_FIELD_W];
  endfunction : field_of

  // a field takes new data only on a write that hits this register
  function automatic gps_sel_t field_next(
    input gps_sel_t cur,
    input logic [15:0] wd,
    input logic we,
    input int k
  );
    field_next = we ? field_of(wd, k) : cur;
  endfunction : field_next

  assign hit = (req_i.addr == `GPS_ADDR_PIN_SEL);
  assign wr_hit = req_i.wr & hit;

  assign pin7_source_select = field_of(pin_sel_r, `GPS_PIN7);
  assign pin6_source_select = field_of(pin_sel_r, `GPS_PIN6);
  assign pin5_source_select = field_of(pin_sel_r, `GPS_PIN5);
  assign pin4_source_select = field_of(pin_sel_r, `GPS_PIN4);
  assign pin3_source_select = field_of(pin_sel_r, `GPS_PIN3);
  assign pin2_source_select = field_of(pin_sel_r, `GPS_PIN2);
  assign pin1_source_select = field_of(pin_sel_r, `GPS_PIN1);

  assign pin7_sel_nxt = field_next(pin7_source_select, req_i.wdata, wr_hit, `GPS_PIN7);
  assign pin6_sel_nxt = field_next(pin6_source_select, req_i.wdata, wr_hit, `GPS_PIN6);
  assign pin5_sel_nxt = field_next(pin5_source_select, req_i.wdata, wr_hit, `GPS_PIN5);
  assign pin4_sel_nxt = field_next(pin4_source_select, req_i.wdata, wr_hit, `GPS_PIN4);
  assign pin3_sel_nxt = field_next(pin3_source_select, req_i.wdata, wr_hit, `GPS_PIN3);
  assign pin2_sel_nxt = field_next(pin2_source_select, req_i.wdata, wr_hit, `GPS_PIN2);
  assign pin1_sel_nxt = field_next(pin1_source_select, req_i.wdata, wr_hit, `GPS_PIN1);

  // bits 1:0 carry no pin field: writes dropped, reads zero
  assign pin_sel_nxt = {
    pin7_sel_nxt,
    pin6_sel_nxt,
    pin5_sel_nxt,
    pin4_sel_nxt,
    pin3_sel_nxt,
    pin2_sel_nxt,
    pin1_sel_nxt,
    `GPS_RSVD_BITS
  };

  assign rd_data = {
    pin7_source_select,
    pin6_source_select,
    pin5_source_select,
    pin4_source_select,
    pin3_source_select,
    pin2_source_select,
    pin1_source_select,
    `GPS_RSVD_BITS
  };
  assign rd_mux = hit ? rd_data : `GPS_RDATA_RESET;

  assign sel_of_pin[`GPS_PIN7] = pin7_source_select;
  assign sel_of_pin[`GPS_PIN6] = pin6_source_select;
  assign sel_of_pin[`GPS_PIN5] = pin5_source_select;
  assign sel_of_pin[`GPS_PIN4] = pin4_source_select;
  assign sel_of_pin[`GPS_PIN3] = pin3_source_select;
  assign sel_of_pin[`GPS_PIN2] = pin2_source_select;
  assign sel_of_pin[`GPS_PIN1] = pin1_source_select;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sel_r <= `GPS_PIN_SEL_RESET;
      rdata_o <= `GPS_RDATA_RESET;
    end else begin
      pin_sel_r <= pin_sel_nxt;
      if (req_i.rd) begin
        rdata_o <= rd_mux;
      end
    end
  end

  // software is trusted to write only code 11; other codes release the pin
  genvar g;
  generate
    for (g = `GPS_FIRST_PIN; g <= `GPS_LAST_PIN; g = g + 1) begin : g_pin
      wire gps_drive_t drv;
      assign drv.out_val = out_val_i[g];
      assign drv.oe_val = oe_val_i[g];
      gps_pin_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(sel_of_pin[g]),
        .drive_i(drv),
        .pin_i(pin_i[g]),
        .pin_o(pin_o[g]),
        .pin_oe_n_o(pin_oe_n_o[g]),
        .in_val_o(in_val_o[g])
      );
    end
  endgenerate
endmodule : gps_top
`default_nettype wire

// >>> rtl/gps_map.svh
// register map and constants of the pin source-select block
// assumes the management side has already chosen the general-purpose page
// Functional notes
// - pin 7 select in bits 15:14, resets 00
// - code 11 hands pin to in/out/enable registers
// - pin 6 select in bits 13:12
// - pin 5 select in bits 11:10
// - pin 4 select in bits 9:8
// - pin 3 select in bits 7:6
// - pin 2 select in bits 5:4
// - pin 1 select in bits 3:2
`ifndef GPS_MAP_SVH
`define GPS_MAP_SVH
`define GPS_ADDR_PIN_SEL 5'h0d
`define GPS_PIN_SEL_RESET 16'h0000
`define GPS_PIN_SEL_WMASK 16'hfffc
`define GPS_SEL_RESET 2'h0
`define GPS_SEL_GPIO 2'h3
`define GPS_FIRST_PIN 1
`define GPS_LAST_PIN 7
`define GPS_FIELD_W 2
`define GPS_PIN1 1
`define GPS_PIN2 2
`define GPS_PIN3 3
`define GPS_PIN4 4
`define GPS_PIN5 5
`define GPS_PIN6 6
`define GPS_PIN7 7
`define GPS_RSVD_BITS 2'h0
`define GPS_RDATA_RESET 16'h0000
`endif

// >>> rtl/gps_pkg.sv
// types of the pin source-select block
// used by the pin cell and the top module
`default_nettype none
package gps_pkg;
  typedef logic [1:0] gps_sel_t;
  typedef struct packed {
    logic out_val;
    logic oe_val;
  } gps_drive_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } gps_reg_req_t;
endpackage : gps_pkg
`default_nettype wire

// >>> rtl/gps_pin_cell.sv
// one general-purpose pin: drive under its select code, sampled input
// assumes pin_i is asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
`include "gps_map.svh"
module gps_pin_cell
  import gps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gps_sel_t sel_i,
  input wire gps_drive_t drive_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n_o,
  output logic in_val_o
);
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  wire logic owned;
  wire logic agree;
  assign owned = (sel_i == `GPS_SEL_GPIO);
  assign agree = (sync2_r == sync3_r);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
      in_val_o <= 1'b0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_o <= owned & drive_i.out_val;
      pin_oe_n_o <= ~(owned & drive_i.oe_val);
      if (!owned) begin
        in_val_o <= 1'b0;
      end else if (agree) begin
        in_val_o <= sync3_r;
      end
    end
  end
endmodule : gps_pin_cell
`default_nettype wire

// >>> tb/gps_top_checker.sv
// gps_top port checker and the bind that attaches it
// assumes one clock domain and the synchronous active-high reset of gps_top
`timescale 1ns/1ps
`default_nettype none
`include "gps_map.svh"
module gps_top_checker
  import gps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire gps_reg_req_t req_i,
  input wire logic [15:0] rdata_o,
  input wire logic [7:1] out_val_i,
  input wire logic [7:1] oe_val_i,
  input wire logic [7:1] in_val_o,
  input wire logic [7:1] pin_o,
  input wire logic [7:1] pin_oe_n_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic h;
  wire logic w;
  wire logic r;
  assign h = (req_i.addr == `GPS_ADDR_PIN_SEL);
  assign w = req_i.wr && h;
  assign r = req_i.rd && !req_i.wr;
  a_read_back: assert property (w ##1 !w [*3] ##1 r && h |=>
    rdata_o == ($past(req_i.wdata, 5) & `GPS_PIN_SEL_WMASK)) else $error("readback");
  a_low_zero: assert property (r |=> !rdata_o[1:0]) else $error("low bits");
  a_bad_addr: assert property (r && !h |=> !rdata_o) else $error("bad addr");
  a_reset_clear: assert property ($fell(rst_i) |->
    !rdata_o && !pin_o && !in_val_o && &pin_oe_n_o) else $error("reset state");
  a_out_follows: assert property (!(pin_o & ~$past(out_val_i))) else $error("out");
  a_oe_follows: assert property (!(~pin_oe_n_o & ~$past(oe_val_i))) else $error("oe");
  a_full_own: assert property (w && &(req_i.wdata | ~`GPS_PIN_SEL_WMASK) ##1 !w [*2] |->
    pin_o == $past(out_val_i) && pin_oe_n_o == ~$past(oe_val_i)) else $error("own");
  a_all_free: assert property (w && !(req_i.wdata & req_i.wdata >> 1 & 16'h5554)
    ##1 !w [*2] |-> !pin_o && !in_val_o && &pin_oe_n_o) else $error("free");
  c_wr: cover property (w);
  c_bad: cover property (r && !h);
  c_own: cover property (!pin_oe_n_o[7]);
endmodule : gps_top_checker
bind gps_top gps_top_checker chk_u (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .req_i(req_i),
  .rdata_o(rdata_o),
  .out_val_i(out_val_i),
  .oe_val_i(oe_val_i),
  .in_val_o(in_val_o),
  .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o)
);
`default_nettype wire

// >>> tb/gps_pin_source_select_test.sv
// bench of gps_top: register readback, reserved bits, pin hand-over, resets
// assumes the map header on the include path; drives all inputs at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "gps_map.svh"
module gps_pin_source_select_test
  import gps_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  gps_reg_req_t q = '0;
  logic [15:0] rd;
  logic [15:0] d;
  logic [7:1] ov = 7'h00;
  logic [7:1] oe = 7'h00;
  logic [7:1] iv;
  logic [7:1] pi = 7'h00;
  logic [7:1] po;
  logic [7:1] pn;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 33;

  gps_top dut_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(q),
    .rdata_o(rd),
    .out_val_i(ov),
    .oe_val_i(oe),
    .in_val_o(iv),
    .pin_i(pi),
    .pin_o(po),
    .pin_oe_n_o(pn)
  );

  initial begin
    forever begin
      #25 clk_i = ~clk_i;
    end
  end

  // register image: pin fields 1..7 kept, bits 1:0 read zero
  function automatic logic [15:0] exp_reg(input logic [15:0] v);
    logic [15:0] e;
    e = 16'h0000;
    for (int k = 1; k <= 7; k++) begin
      e[2*k +: 2] = v[2*k +: 2];
    end
    return e;
  endfunction : exp_reg

  // pins whose field holds code 11
  function automatic logic [7:1] exp_own(input logic [15:0] v);
    logic [7:1] m;
    m = 7'h00;
    for (int k = 1; k <= 7; k++) begin
      m[k] = (v[2*k +: 2] == 2'h3);
    end
    return m;
  endfunction : exp_own

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // pin outputs and sampled inputs against the owned mask
  task automatic chk_pins(input logic [7:1] m);
    chk({po, pn, 2'h0}, {ov & m, ~(oe & m), 2'h0});
    chk({iv, 9'h000}, {pi & m, 9'h000});
  endtask : chk_pins

  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v);
    @(negedge clk_i);
    q = '{w, !w, a, v};
    @(negedge clk_i);
    q.wr = 1'b0;
    q.rd = 1'b0;
  endtask : acc

  task end_of_test;
    $display("fails %0d of %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {ov, oe, pi} = 21'($random(seed));
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    acc(1'b0, `GPS_ADDR_PIN_SEL, 16'h0000);
    chk(rd, 16'h0000);
    chk_pins(7'h00);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 16'hffff : 16'($random(seed));
      acc(1'b1, `GPS_ADDR_PIN_SEL, d);
      acc(1'b1, d[4:0] | 5'h10, ~d);
      acc(1'b0, `GPS_ADDR_PIN_SEL, 16'h0000);
      chk(rd, exp_reg(d));
      chk_pins(exp_own(d));
      acc(1'b0, d[4:0] | 5'h10, 16'h0000);
      chk(rd, 16'h0000);
    end
    acc(1'b1, `GPS_ADDR_PIN_SEL, 16'hfffc);
    repeat (8) begin
      {ov, oe, pi} = 21'($random(seed));
      repeat (5) @(negedge clk_i);
      chk_pins(7'h7f);
    end
    acc(1'b1, `GPS_ADDR_PIN_SEL, 16'hc00c);
    {ov, oe, pi} = 21'($random(seed));
    repeat (5) @(negedge clk_i);
    chk_pins(7'h41);
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    acc(1'b0, `GPS_ADDR_PIN_SEL, 16'h0000);
    chk(rd, 16'h0000);
    chk_pins(7'h00);
    acc(1'b1, `GPS_ADDR_PIN_SEL, 16'h5aa8);
    repeat (4) @(negedge clk_i);
    chk({po, pn, 2'h0}, 16'h01fc);
    chk_pins(7'h00);
    end_of_test;
  end
endmodule : gps_pin_source_select_test
`default_nettype wire
